/* dv/radio_deviation_and_state_config_bench.sv */
// self-checking bench for the radio config block
`timescale 1ns/1ps
`default_nettype none
`include "rdsc_regs.vh"
module radio_deviation_and_state_config_bench;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [15:0] i_addr = 16'h0000, i_wake_period_a = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic [1:0] i_wake_resolution = 2'h0;
  logic i_mod_msk = 1'b0, i_mod_ask = 1'b0, i_rc_clk = 1'b0, i_rx_start = 1'b0;
  logic i_rx_abort = 1'b0, i_sync_found = 1'b0, i_preamble_qual_met = 1'b0, i_cs_valid = 1'b0;
  logic i_carrier_sense = 1'b0, i_symbol_tick = 1'b0, i_rssi_below_thr = 1'b0;
  logic i_receiving_pkt = 1'b0, i_pkt_rx_done = 1'b0, i_pkt_tx_done = 1'b0;
  wire [7:0] o_rdata;
  wire [3:0] o_dev_mant4, o_next_state;
  wire [2:0] o_dev_exp, o_msk_phase_frac;
  wire [10:0] o_dev_mult;
  wire o_rx_end, o_rx_timeout, o_clear_channel_flag, o_next_state_vld, o_tx_preamble;
  int num_errors = 0;
  int check_count = 0;

  rdsc_top dut_u (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_mod_msk,
    .i_mod_ask, .i_wake_period_a, .i_wake_resolution, .i_rc_clk, .i_rx_start, .i_rx_abort,
    .i_sync_found, .i_preamble_qual_met, .i_cs_valid, .i_carrier_sense, .i_symbol_tick,
    .i_rssi_below_thr, .i_receiving_pkt, .i_pkt_rx_done, .i_pkt_tx_done, .o_dev_mant4,
    .o_dev_exp, .o_dev_mult, .o_msk_phase_frac, .o_rx_end, .o_rx_timeout,
    .o_clear_channel_flag, .o_next_state, .o_next_state_vld, .o_tx_preamble);

  always #2.5 i_clk_sys = ~i_clk_sys;
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk_sys) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
    @(posedge i_clk_sys) i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys) begin i_rd <= 1'b1; i_addr <= a; end
    @(posedge i_clk_sys) i_rd <= 1'b0;
    #1 check(o_rdata, exp);
  endtask
  task automatic done_pulse(input logic rx, input logic [3:0] st, input logic pre);
    @(posedge i_clk_sys) begin i_pkt_rx_done <= rx; i_pkt_tx_done <= !rx; end
    @(posedge i_clk_sys) begin i_pkt_rx_done <= 1'b0; i_pkt_tx_done <= 1'b0; end
    #1 check(o_next_state_vld, 1);
    check(o_next_state, st);
    check(o_tx_preamble, pre);
  endtask
  // mode 1 runs the rc clock, 2 sends symbol ticks, 3 one carrier-sense result
  task automatic rx_case(input logic [7:0] cfg, input logic [15:0] ev, input logic [1:0] res,
      input int mode, input int lim, input logic ee, input logic et, input int en);
    logic e, t;
    int n, c;
    wr(`RDSC_RX_TMO_OFF, cfg);
    i_wake_period_a <= ev;
    i_wake_resolution <= res;
    e = 1'b0;
    t = 1'b0;
    n = 0;
    @(posedge i_clk_sys) i_rx_start <= 1'b1;
    @(posedge i_clk_sys) i_rx_start <= 1'b0;
    for (c = 0; c < lim && !e; c++) begin
      @(posedge i_clk_sys);
      i_symbol_tick <= (mode == 2 && c % 8 == 3);
      i_cs_valid <= (mode == 3 && c == 5);
      if (mode == 1 && c % 8 == 7) begin
        i_rc_clk <= !i_rc_clk;
        n += !i_rc_clk;
      end
      if (mode == 2 && c % 8 == 3) n++;
      #1 e = o_rx_end;
      t = o_rx_timeout;
    end
    // abort also returns a search that never ended to idle
    @(posedge i_clk_sys) begin i_symbol_tick <= 1'b0; i_cs_valid <= 1'b0; i_rx_abort <= 1'b1; end
    @(posedge i_clk_sys) i_rx_abort <= 1'b0;
    check(e, ee);
    check(t, et);
    if (en >= 0) check(16'(n), 16'(en));
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1 check(o_dev_mant4, 4'hF);
    check(o_dev_mult, 11'h0F0);
    check(o_dev_exp, 3'h4);
    rd(`RDSC_FREQ_DEV_OFF, 8'h47);
    rd(`RDSC_RX_TMO_OFF, 8'h07);
    rd(`RDSC_POST_PKT_OFF, 8'h30);
    wr(`RDSC_RX_TMO_OFF, 8'hFF);
    rd(`RDSC_RX_TMO_OFF, 8'h1F);
    wr(`RDSC_POST_PKT_OFF, 8'hFF);
    rd(`RDSC_POST_PKT_OFF, 8'h3F);
    wr(16'hDF14, 8'h55);
    rd(16'hDF14, 8'h00);
    $display("test done: registers");
    wr(`RDSC_FREQ_DEV_OFF, 8'hAD);
    rd(`RDSC_FREQ_DEV_OFF, 8'h25);
    #1 check(o_dev_mant4, 4'hD);
    check(o_dev_mult, 11'h034);
    check(o_dev_exp, 3'h2);
    @(posedge i_clk_sys) i_mod_msk <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1 check(o_msk_phase_frac, 3'h5);
    check(o_dev_mant4, 4'h0);
    check(o_dev_mult, 11'h000);
    check(o_dev_exp, 3'h0);
    @(posedge i_clk_sys) i_mod_msk <= 1'b0;
    $display("test done: deviation");
    for (int m = 0; m < 4; m++) begin
      wr(`RDSC_POST_PKT_OFF, 8'(m << 4));
      for (int k = 0; k < 4; k++) begin
        @(posedge i_clk_sys) begin i_rssi_below_thr <= k[0]; i_receiving_pkt <= k[1]; end
        repeat (2) @(posedge i_clk_sys);
        #1 check(o_clear_channel_flag, (m == 0) || (m == 1 && k[0]) || (m == 2 && !k[1])
          || (m == 3 && k[0] && !k[1]));
      end
      if (m == 0) rd(`RDSC_STATUS_OFF, 8'h11);
    end
    $display("test done: clear channel");
    for (int k = 0; k < 4; k++) begin
      wr(`RDSC_POST_PKT_OFF, 8'(k * 5));
      done_pulse(1'b1, 4'h1 << k, 1'b0);
      done_pulse(1'b0, 4'h1 << k, k == 2);
    end
    $display("test done: next state");
    rx_case(8'h03, 16'h0080, 2'h1, 1, 1500, 1, 1, 32);
    rx_case(8'h03, 16'h0080, 2'h0, 1, 1500, 1, 1, 2);
    rx_case(8'h00, 16'h0040, 2'h0, 1, 1500, 1, 1, 8);
    rx_case(8'h06, 16'h8000, 2'h0, 1, 1500, 1, 1, 64);
    rx_case(8'h07, 16'h0080, 2'h0, 1, 600, 0, 0, -1);
    rx_case(8'h03, 16'h0080, 2'h0, 0, 300, 0, 0, 0);
    i_preamble_qual_met <= 1'b1;
    rx_case(8'h03, 16'h0080, 2'h0, 1, 1500, 1, 1, 2);
    rx_case(8'h0B, 16'h0080, 2'h0, 1, 200, 0, 0, -1);
    i_preamble_qual_met <= 1'b0;
    i_sync_found <= 1'b1;
    rx_case(8'h03, 16'h0080, 2'h0, 1, 200, 0, 0, -1);
    i_sync_found <= 1'b0;
    rx_case(8'h17, 16'h0080, 2'h0, 3, 100, 1, 0, 0);
    i_mod_ask <= 1'b1;
    rx_case(8'h17, 16'h0080, 2'h0, 2, 200, 1, 1, 8);
    i_mod_ask <= 1'b0;
    $display("test done: receive supervision");
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    num_errors++;
    stop_test();
  end
endmodule // radio_deviation_and_state_config_bench
`default_nettype wire

/* dv/rdsc_asserts.sv */
// concurrent checks on the radio config block ports
`timescale 1ns/1ps
`default_nettype none
module rdsc_asserts (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_rd,
  input wire i_mod_msk,
  input wire i_pkt_rx_done,
  input wire i_pkt_tx_done,
  input wire [7:0] o_rdata,
  input wire [3:0] o_dev_mant4,
  input wire [2:0] o_dev_exp,
  input wire [10:0] o_dev_mult,
  input wire o_rx_end,
  input wire o_rx_timeout,
  input wire [3:0] o_next_state,
  input wire o_next_state_vld,
  input wire o_tx_preamble
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_done;
    i_pkt_rx_done || i_pkt_tx_done;
  endsequence
  sequence s_fsk_held;
    (!i_mod_msk) [*2];
  endsequence
  sequence s_msk_held;
    i_mod_msk [*2];
  endsequence
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_dev_mult: assert property (o_dev_mult == ({7'h00, o_dev_mant4} << o_dev_exp))
    else $error("deviation multiplier does not match mantissa and exponent");
  a_mant_msb: assert property (s_fsk_held |=> o_dev_mant4[3])
    else $error("implied mantissa one missing in fsk");
  a_msk_zero: assert property (s_msk_held |=> o_dev_mant4 == 4'h0 && o_dev_mult == 11'h000)
    else $error("deviation outputs not cleared in msk");
  a_timeout_end: assert property (o_rx_timeout |-> o_rx_end)
    else $error("timeout without receive end");
  a_end_pulse: assert property (o_rx_end |=> !o_rx_end)
    else $error("receive end longer than one cycle");
  a_done_vld: assert property (s_done |=> o_next_state_vld)
    else $error("packet done without next state update");
  a_vld_cause: assert property (o_next_state_vld |-> $past(i_pkt_rx_done || i_pkt_tx_done))
    else $error("next state update without packet done");
  a_state_onehot: assert property ($onehot(o_next_state))
    else $error("next state not one-hot");
  a_preamble_tx: assert property (o_tx_preamble |-> o_next_state_vld && o_next_state == 4'h4)
    else $error("preamble pulse without stay in transmit");
endmodule // rdsc_asserts
bind rdsc_top rdsc_asserts chk_u (.i_clk_sys, .i_rst, .i_rd, .i_mod_msk, .i_pkt_rx_done,
  .i_pkt_tx_done, .o_rdata, .o_dev_mant4, .o_dev_exp, .o_dev_mult, .o_rx_end, .o_rx_timeout,
  .o_next_state, .o_next_state_vld, .o_tx_preamble);
`default_nettype wire

/* hdl/rdsc_regs.vh */
// register offsets, field positions, reset values and timing counts for the radio config block
`ifndef RDSC_REGS_VH
`define RDSC_REGS_VH

`define RDSC_ADDR_W 16
`define RDSC_FREQ_DEV_OFF 16'hDF11
`define RDSC_RX_TMO_OFF 16'hDF12
`define RDSC_POST_PKT_OFF 16'hDF13
`define RDSC_STATUS_OFF 16'hDF20

`define RDSC_FREQ_DEV_RST 8'h47
`define RDSC_RX_TMO_RST 8'h07
`define RDSC_POST_PKT_RST 8'h30
`define RDSC_DEV_E_RST 3'h4
`define RDSC_DEV_M_RST 3'h7
`define RDSC_RX_RSSI_RST 1'h0
`define RDSC_RX_QUAL_RST 1'h0
`define RDSC_RX_TIME_RST 3'h7
`define RDSC_CLR_SEL_RST 2'h3
`define RDSC_RXOFF_RST 2'h0
`define RDSC_TXOFF_RST 2'h0

`define RDSC_DEV_E_MSB 6
`define RDSC_DEV_E_LSB 4
`define RDSC_DEV_M_MSB 2
`define RDSC_DEV_M_LSB 0
`define RDSC_RX_RSSI_BIT 4
`define RDSC_RX_QUAL_BIT 3
`define RDSC_RX_TIME_MSB 2
`define RDSC_RX_TIME_LSB 0
`define RDSC_CLR_SEL_MSB 5
`define RDSC_CLR_SEL_LSB 4
`define RDSC_RXOFF_MSB 3
`define RDSC_RXOFF_LSB 2
`define RDSC_TXOFF_MSB 1
`define RDSC_TXOFF_LSB 0

`define RDSC_RX_TIME_NONE 3'h7
`define RDSC_ASK_SYMS 4'h8
`define RDSC_TMO_SHIFT 3
`define RDSC_RES_SHIFT_STEP 4

`define RDSC_NXT_IDLE 4'h1
`define RDSC_NXT_SYNTH 4'h2
`define RDSC_NXT_TX 4'h4
`define RDSC_NXT_RX 4'h8

`endif

/* hdl/rdsc_tcnt.v */
// down-counter for the sync-search timeout, counting prescaled rc ticks
`timescale 1ns/1ps
`default_nettype none
module rdsc_tcnt (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_load,
  input wire [12:0] i_load_val,
  input wire i_stop,
  input wire i_tick,
  output reg o_expire,
  output reg o_running
);
  reg [12:0] cnt_ff;

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= 13'h0000;
      o_running <= 1'b0;
      o_expire <= 1'b0;
    end else begin
      o_expire <= 1'b0;
      if (i_stop) begin
        o_running <= 1'b0;
      end else if (i_load) begin
        cnt_ff <= i_load_val;
        o_running <= 1'b1;
      end else if (o_running && i_tick) begin
        // a zero load expires on the first tick rather than wrapping
        if (cnt_ff <= 13'h0001) begin
          o_expire <= 1'b1;
          o_running <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 13'h0001;
        end
      end
    end
  end
endmodule // rdsc_tcnt
`default_nettype wire

/* hdl/rdsc_top.v */
// deviation setting and radio state machine configuration registers with rx supervision
`timescale 1ns/1ps
`default_nettype none
`include "rdsc_regs.vh"
module rdsc_top (
  input wire i_clk_sys,
  input wire i_rst,
  input wire [15:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_mod_msk,
  input wire i_mod_ask,
  input wire [15:0] i_wake_period_a,
  input wire [1:0] i_wake_resolution,
  input wire i_rc_clk,
  input wire i_rx_start,
  input wire i_rx_abort,
  input wire i_sync_found,
  input wire i_preamble_qual_met,
  input wire i_cs_valid,
  input wire i_carrier_sense,
  input wire i_symbol_tick,
  input wire i_rssi_below_thr,
  input wire i_receiving_pkt,
  input wire i_pkt_rx_done,
  input wire i_pkt_tx_done,
  output reg [3:0] o_dev_mant4,
  output reg [2:0] o_dev_exp,
  output reg [10:0] o_dev_mult,
  output reg [2:0] o_msk_phase_frac,
  output reg o_rx_end,
  output reg o_rx_timeout,
  output reg o_clear_channel_flag,
  output reg [3:0] o_next_state,
  output reg o_next_state_vld,
  output reg o_tx_preamble
);
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [2:0] dev_e_ff;
  reg [2:0] dev_m_ff;
  reg rx_end_on_carrier_sense_ff;
  reg rx_timeout_qualifier_ff;
  reg [2:0] rx_timeout_select_ff;
  reg [1:0] clear_channel_select_ff;
  reg [1:0] after_rx_state_ff;
  reg [1:0] after_tx_state_ff;

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dev_e_ff <= `RDSC_DEV_E_RST;
      dev_m_ff <= `RDSC_DEV_M_RST;
      rx_end_on_carrier_sense_ff <= `RDSC_RX_RSSI_RST;
      rx_timeout_qualifier_ff <= `RDSC_RX_QUAL_RST;
      rx_timeout_select_ff <= `RDSC_RX_TIME_RST;
      clear_channel_select_ff <= `RDSC_CLR_SEL_RST;
      after_rx_state_ff <= `RDSC_RXOFF_RST;
      after_tx_state_ff <= `RDSC_TXOFF_RST;
    end else if (i_wr) begin
      // only the defined fields are stored; reserved bits are dropped
      case (i_addr)
        `RDSC_FREQ_DEV_OFF: begin
          dev_e_ff <= i_wdata[`RDSC_DEV_E_MSB:`RDSC_DEV_E_LSB];
          dev_m_ff <= i_wdata[`RDSC_DEV_M_MSB:`RDSC_DEV_M_LSB];
        end
        `RDSC_RX_TMO_OFF: begin
          rx_end_on_carrier_sense_ff <= i_wdata[`RDSC_RX_RSSI_BIT];
          rx_timeout_qualifier_ff <= i_wdata[`RDSC_RX_QUAL_BIT];
          rx_timeout_select_ff <= i_wdata[`RDSC_RX_TIME_MSB:`RDSC_RX_TIME_LSB];
        end
        `RDSC_POST_PKT_OFF: begin
          clear_channel_select_ff <= i_wdata[`RDSC_CLR_SEL_MSB:`RDSC_CLR_SEL_LSB];
          after_rx_state_ff <= i_wdata[`RDSC_RXOFF_MSB:`RDSC_RXOFF_LSB];
          after_tx_state_ff <= i_wdata[`RDSC_TXOFF_MSB:`RDSC_TXOFF_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // rx supervision state machine
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SRCH = 3'h2;
  localparam [2:0] ST_PKT = 3'h4;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  wire tmo_expire;
  wire tmo_running;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  reg [7:0] nxt_rdata;

  always @* begin
    nxt_rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `RDSC_FREQ_DEV_OFF: nxt_rdata = {1'h0, dev_e_ff, 1'h0, dev_m_ff};
        `RDSC_RX_TMO_OFF: nxt_rdata = {3'h0, rx_end_on_carrier_sense_ff, rx_timeout_qualifier_ff,
                                      rx_timeout_select_ff};
        `RDSC_POST_PKT_OFF: nxt_rdata = {2'h0, clear_channel_select_ff, after_rx_state_ff,
                                        after_tx_state_ff};
        `RDSC_STATUS_OFF: nxt_rdata = {3'h0, o_clear_channel_flag, tmo_running, state_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // deviation outputs
  // ----------------------------------------------------------------
  wire [3:0] mant4;
  assign mant4 = {1'b1, dev_m_ff};

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_dev_mant4 <= 4'h0;
      o_dev_exp <= 3'h0;
      o_dev_mult <= 11'h000;
      o_msk_phase_frac <= 3'h0;
    end else if (i_mod_msk) begin
      // msk reuses the mantissa as a phase-change fraction
      o_dev_mant4 <= 4'h0;
      o_dev_exp <= 3'h0;
      o_dev_mult <= 11'h000;
      o_msk_phase_frac <= dev_m_ff;
    end else begin
      o_dev_mant4 <= mant4;
      o_dev_exp <= dev_e_ff;
      // deviation in units of f_xosc / 2^17
      o_dev_mult <= {7'h00, mant4} << dev_e_ff;
      o_msk_phase_frac <= 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // rc oscillator synchroniser and prescaler
  // ----------------------------------------------------------------
  reg rc_meta_ff;
  reg rc_sync_ff;
  reg rc_prev_ff;
  reg [11:0] presc_ff;
  reg tick_ff;
  wire rc_edge;
  wire [11:0] presc_top;

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rc_meta_ff <= 1'b0;
      rc_sync_ff <= 1'b0;
      rc_prev_ff <= 1'b0;
    end else begin
      rc_meta_ff <= i_rc_clk;
      rc_sync_ff <= rc_meta_ff;
      rc_prev_ff <= rc_sync_ff;
    end
  end

  // the timeout counter runs only on rc periods; with the oscillator off only the ask window can time out
  assign rc_edge = rc_sync_ff & ~rc_prev_ff;
  // wake period scales 2^(5*res), the rx timeout one bit less per step: 2^(4*res)
  assign presc_top = (12'h001 << (`RDSC_RES_SHIFT_STEP * i_wake_resolution)) - 12'h001;

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      presc_ff <= 12'h000;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (i_rx_start) begin
        presc_ff <= 12'h000;
      end else if (rc_edge) begin
        if (presc_ff >= presc_top) begin
          presc_ff <= 12'h000;
          tick_ff <= 1'b1;
        end else begin
          presc_ff <= presc_ff + 12'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // timeout counter
  // ----------------------------------------------------------------
  wire [12:0] tmo_load_val;
  wire tmo_enabled;
  wire tmo_load;
  wire tmo_stop;

  // top 13 bits of wake_period_a at setting 0, down to 7 bits at 6
  assign tmo_load_val = i_wake_period_a[15:`RDSC_TMO_SHIFT] >> rx_timeout_select_ff;
  assign tmo_enabled = (rx_timeout_select_ff != `RDSC_RX_TIME_NONE);
  assign tmo_load = i_rx_start & tmo_enabled;
  assign tmo_stop = ~state_ff[1] & ~i_rx_start;

  rdsc_tcnt u_tcnt (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_load(tmo_load),
    .i_load_val(tmo_load_val),
    .i_stop(tmo_stop),
    .i_tick(tick_ff),
    .o_expire(tmo_expire),
    .o_running(tmo_running)
  );

  // ----------------------------------------------------------------
  // ask carrier-sense window
  // ----------------------------------------------------------------
  reg [3:0] sym_cnt_ff;
  reg cs_seen_ff;
  wire ask_window_end;

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sym_cnt_ff <= 4'h0;
      cs_seen_ff <= 1'b0;
    end else if (i_rx_start) begin
      sym_cnt_ff <= 4'h0;
      cs_seen_ff <= 1'b0;
    end else if (state_ff == ST_SRCH) begin
      if (i_carrier_sense) begin
        cs_seen_ff <= 1'b1;
      end
      if (i_symbol_tick && sym_cnt_ff != `RDSC_ASK_SYMS) begin
        sym_cnt_ff <= sym_cnt_ff + 4'h1;
      end
    end
  end

  // fires once, on the eighth symbol tick without carrier sense
  assign ask_window_end = rx_end_on_carrier_sense_ff & i_mod_ask & i_symbol_tick &
                          ~cs_seen_ff & ~i_carrier_sense &
                          (sym_cnt_ff == `RDSC_ASK_SYMS - 4'h1);

  // ----------------------------------------------------------------
  // receive termination
  // ----------------------------------------------------------------
  reg nxt_end;
  reg nxt_tmo;
  wire keep_rx;
  wire cs_end;

  // qualifier picks whether a preamble hit alone keeps the receiver on
  assign keep_rx = i_sync_found | (rx_timeout_qualifier_ff & i_preamble_qual_met);
  assign cs_end = rx_end_on_carrier_sense_ff & i_cs_valid & ~i_carrier_sense;

  always @* begin
    nxt_state = state_ff;
    nxt_end = 1'b0;
    nxt_tmo = 1'b0;
    case (state_ff)
      ST_IDLE: if (i_rx_start) nxt_state = ST_SRCH;
      ST_SRCH: begin
        if (i_rx_abort) begin
          nxt_state = ST_IDLE;
        end else if (i_sync_found) begin
          nxt_state = ST_PKT;
        end else if (cs_end) begin
          nxt_state = ST_IDLE;
          nxt_end = 1'b1;
        end else if (ask_window_end) begin
          nxt_state = ST_IDLE;
          nxt_end = 1'b1;
          nxt_tmo = 1'b1;
        end else if (tmo_expire) begin
          if (keep_rx) begin
            nxt_state = ST_PKT;
          end else begin
            nxt_state = ST_IDLE;
            nxt_end = 1'b1;
            nxt_tmo = 1'b1;
          end
        end
      end
      // without a timeout the receiver waits here for the packet end
      ST_PKT: if (i_rx_abort || i_pkt_rx_done) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      o_rx_end <= 1'b0;
      o_rx_timeout <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      o_rx_end <= nxt_end;
      o_rx_timeout <= nxt_tmo;
    end
  end

  // ----------------------------------------------------------------
  // clear channel indication
  // ----------------------------------------------------------------
  reg nxt_clear_ch;

  always @* begin
    case (clear_channel_select_ff)
      2'h0: nxt_clear_ch = 1'h1;
      2'h1: nxt_clear_ch = i_rssi_below_thr;
      2'h2: nxt_clear_ch = ~i_receiving_pkt;
      default: nxt_clear_ch = i_rssi_below_thr & ~i_receiving_pkt;
    endcase
  end

  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_clear_channel_flag <= 1'b0;
    end else begin
      o_clear_channel_flag <= nxt_clear_ch;
    end
  end

  // ----------------------------------------------------------------
  // state after packet end
  // ----------------------------------------------------------------
  reg [3:0] nxt_after_rx;
  reg [3:0] nxt_after_tx;

  always @* begin
    case (after_rx_state_ff)
      2'h0: nxt_after_rx = `RDSC_NXT_IDLE;
      2'h1: nxt_after_rx = `RDSC_NXT_SYNTH;
      2'h2: nxt_after_rx = `RDSC_NXT_TX;
      default: nxt_after_rx = `RDSC_NXT_RX;
    endcase
    case (after_tx_state_ff)
      2'h0: nxt_after_tx = `RDSC_NXT_IDLE;
      2'h1: nxt_after_tx = `RDSC_NXT_SYNTH;
      2'h2: nxt_after_tx = `RDSC_NXT_TX;
      default: nxt_after_tx = `RDSC_NXT_RX;
    endcase
  end

  // rx end wins if both arrive together; the radio cannot be in both at once
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_next_state <= `RDSC_NXT_IDLE;
      o_next_state_vld <= 1'b0;
      o_tx_preamble <= 1'b0;
    end else begin
      o_next_state_vld <= 1'b0;
      o_tx_preamble <= 1'b0;
      if (i_pkt_rx_done) begin
        o_next_state <= nxt_after_rx;
        o_next_state_vld <= 1'b1;
      end else if (i_pkt_tx_done) begin
        o_next_state <= nxt_after_tx;
        o_next_state_vld <= 1'b1;
        o_tx_preamble <= (after_tx_state_ff == 2'h2);
      end
    end
  end
endmodule // rdsc_top
`default_nettype wire
